// [rtl/rpcl_pkg.sv]
// package: constants and types for the remote power command listener
package rpcl_pkg;

  localparam logic [7:0]  CHAR_ESC     = 8'h1b;
  localparam logic [7:0]  CHAR_ENTER   = 8'h0d;
  localparam logic [7:0]  CHAR_CARET   = 8'h5e;
  localparam int          BUF_DEPTH    = 15;
  localparam int          BUF_AW       = 4;
  localparam int          CNT_W        = 20;
  localparam logic [CNT_W-1:0] MIN_BIT = 20'h00004;
  localparam logic [CNT_W-1:0] CNT_ONE = 20'h00001;
  localparam logic [BUF_AW-1:0] BUF_LAST = 4'he;

  // command words, stored as up to 9 characters, first character lowest
  localparam int          CMD_LEN_ON    = 7;
  localparam int          CMD_LEN_OFF   = 8;
  localparam int          CMD_LEN_TON   = 8;
  localparam int          CMD_LEN_SLEEP = 9;

  typedef enum logic [5:0]
  {
    RX_IDLE  = 6'b000001,
    RX_MEAS  = 6'b000010,
    RX_HALF  = 6'b000100,
    RX_DATA  = 6'b001000,
    RX_STOP  = 6'b010000,
    RX_WAIT  = 6'b100000
  } rpcl_rx_state_type;

  typedef struct packed
  {
    logic power_on;
    logic power_off_soft;
    logic power_off_now;
  } rpcl_power_cmd_type;

endpackage

// [rtl/rpcl_listener.sv]
// remote power command listener: baud sensing receiver and command matcher
`timescale 1ns/1ps
// Functional notes
// - watch receive line always, even powered off
// - escape then word: on, off, ton, sleep
// - immediate off skips soft power-down
// - sleep ignores commands until re-enabled
// - jumper enabled: first power-on always accepted
// - powered: act only if enabled, not asleep
// - enable setting off: no response, except any command while unpowered with jumper set and first power-on not yet used
// - start bit width sets bit rate
// - fixed buffer; overflow resets listener
module rpcl_listener
  import rpcl_pkg::*;
(
  input  wire logic                i_mclk,
  input  wire logic                i_rst,
  input  wire logic                i_rxd,
  input  wire logic                i_jumper_enable,
  input  wire logic                i_remote_power_enable_setting,
  input  wire logic                i_system_powered,
  output rpcl_power_cmd_type       o_power_cmd,
  output logic                     o_sleeping,
  output logic                     o_first_used
);

  // ---------------------------------------------------------------
  // command word match
  // ---------------------------------------------------------------
  // returns 1 when buffer holds exactly the given text
  function automatic logic match_word(input logic [7:0] buf_in [BUF_DEPTH],
                                      input logic [BUF_AW-1:0] len,
                                      input logic [71:0] word,
                                      input int wlen);
    logic ok;
    ok = (int'(len) == wlen);
    for (int k = 0; k < 9; k++)
    begin
      if (k < wlen && buf_in[k] != word[k*8 +: 8])
        ok = 1'b0;
    end
    return ok;
  endfunction

  // text stored first character in low byte
  localparam logic [71:0] W_ON    = {16'h0000, 56'h6e6f5e73797372};
  localparam logic [71:0] W_OFF   = {8'h00, 64'h66666f5e73797372};
  localparam logic [71:0] W_TON   = {8'h00, 64'h6e6f745e73797372};
  localparam logic [71:0] W_SLEEP = 72'h7065656c735e636970;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  rpcl_rx_state_type  state, next_state;
  logic [CNT_W-1:0]   bit_len, next_bit_len;
  logic [CNT_W-1:0]   cnt, next_cnt;
  logic [2:0]         bit_idx, next_bit_idx;
  logic [7:0]         shreg, next_shreg;
  logic               in_cmd, next_in_cmd;
  logic [BUF_AW-1:0]  len, next_len;
  logic [7:0]         cbuf [BUF_DEPTH];
  logic [7:0]         next_cbuf [BUF_DEPTH];
  logic               sleeping, next_sleeping;
  logic               first_used, next_first_used;
  logic               prev_setting, next_prev_setting;
  rpcl_power_cmd_type cmd_out, next_cmd_out;
  logic               byte_done;
  logic               allowed;
  logic               ovf_rst;

  assign o_power_cmd  = cmd_out;
  assign o_sleeping   = sleeping;
  assign o_first_used = first_used;

  // acceptance gate: first power-on by jumper, else setting and not asleep
  always_comb
  begin
    if (!i_system_powered && i_jumper_enable && !first_used)
      allowed = 1'b1;
    else
      allowed = i_remote_power_enable_setting && !sleeping;
  end

  // ---------------------------------------------------------------
  // receiver with start bit measurement
  // ---------------------------------------------------------------
  always_comb
  begin
    next_state   = state;
    next_bit_len = bit_len;
    next_cnt     = cnt;
    next_bit_idx = bit_idx;
    next_shreg   = shreg;
    byte_done    = 1'b0;
    unique case (state)
      RX_IDLE:
      begin
        if (!i_rxd)
        begin
          next_cnt   = CNT_ONE;
          next_state = in_cmd ? RX_HALF : RX_MEAS;
        end
      end
      RX_MEAS:
      begin
        // first start bit of a command: its low width is the bit period
        if (i_rxd)
        begin
          next_bit_len = (cnt < MIN_BIT) ? MIN_BIT : cnt;
          next_cnt     = CNT_ONE;
          next_bit_idx = 3'h0;
          next_state   = RX_DATA;
        end
        else if (cnt != {CNT_W{1'b1}})
          next_cnt = cnt + CNT_ONE;
      end
      RX_HALF:
      begin
        // later characters: move half a bit into the start bit
        if (cnt >= (bit_len >> 1))
        begin
          next_cnt     = CNT_ONE;
          next_bit_idx = 3'h0;
          next_state   = i_rxd ? RX_IDLE : RX_DATA;
        end
        else
          next_cnt = cnt + CNT_ONE;
      end
      RX_DATA:
      begin
        // after measuring, first sample lands at half a bit in; later bits a full bit apart
        if (cnt >= ((!in_cmd && bit_idx == 3'h0) ? (bit_len >> 1) : bit_len))
        begin
          next_shreg = {i_rxd, shreg[7:1]};
          next_cnt   = CNT_ONE;
          if (bit_idx == 3'h7)
            next_state = RX_STOP;
          else
            next_bit_idx = bit_idx + 3'h1;
        end
        else
          next_cnt = cnt + CNT_ONE;
      end
      RX_STOP:
      begin
        if (cnt >= bit_len)
        begin
          byte_done  = 1'b1;
          next_state = RX_WAIT;
        end
        else
          next_cnt = cnt + CNT_ONE;
      end
      RX_WAIT:
      begin
        if (i_rxd)
          next_state = RX_IDLE;
      end
      default:
        next_state = RX_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // command buffer and decode
  // ---------------------------------------------------------------
  always_comb
  begin
    next_in_cmd       = in_cmd;
    next_len          = len;
    next_cbuf         = cbuf;
    next_sleeping     = sleeping;
    next_first_used   = first_used;
    next_prev_setting = i_remote_power_enable_setting;
    next_cmd_out      = '0;
    ovf_rst           = 1'b0;
    // off then on of the setting wakes the listener
    if (i_remote_power_enable_setting && !prev_setting)
      next_sleeping = 1'b0;
    if (byte_done)
    begin
      next_in_cmd = 1'b1;
      if (shreg == CHAR_ESC)
        next_len = '0;
      else if (shreg == CHAR_ENTER)
      begin
        if (allowed)
        begin
          if (match_word(cbuf, len, W_ON, CMD_LEN_ON))
          begin
            next_cmd_out.power_on = 1'b1;
            if (!i_system_powered)
              next_first_used = 1'b1;
          end
          if (match_word(cbuf, len, W_OFF, CMD_LEN_OFF))
            next_cmd_out.power_off_soft = 1'b1;
          if (match_word(cbuf, len, W_TON, CMD_LEN_TON))
            next_cmd_out.power_off_now = 1'b1;
          if (match_word(cbuf, len, W_SLEEP, CMD_LEN_SLEEP))
            next_sleeping = 1'b1;
        end
        next_in_cmd = 1'b0;
        if (len == BUF_LAST)
          ovf_rst = 1'b1;
        else
          next_len = len + 4'h1;
      end
      else if (len == BUF_LAST)
        ovf_rst = 1'b1;
      else
      begin
        next_cbuf[len] = shreg;
        next_len       = len + 4'h1;
      end
    end
  end

  // registers; buffer overflow clears the command buffer, sleep and pulses as a reset; receiver goes to RX_WAIT
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state        <= RX_IDLE;
      bit_len      <= MIN_BIT;
      cnt          <= '0;
      bit_idx      <= 3'h0;
      shreg        <= 8'h00;
      in_cmd       <= 1'b0;
      len          <= '0;
      cbuf         <= '{default: 8'h00};
      sleeping     <= 1'b0;
      first_used   <= 1'b0;
      prev_setting <= 1'b0;
      cmd_out      <= '0;
    end
    else if (ovf_rst)
    begin
      state        <= RX_WAIT;
      in_cmd       <= 1'b0;
      len          <= '0;
      cbuf         <= '{default: 8'h00};
      sleeping     <= 1'b0;
      prev_setting <= next_prev_setting;
      cmd_out      <= '0;
    end
    else
    begin
      state        <= next_state;
      bit_len      <= next_bit_len;
      cnt          <= next_cnt;
      bit_idx      <= next_bit_idx;
      shreg        <= next_shreg;
      in_cmd       <= next_in_cmd;
      len          <= next_len;
      cbuf         <= next_cbuf;
      sleeping     <= next_sleeping;
      first_used   <= next_first_used;
      prev_setting <= next_prev_setting;
      cmd_out      <= next_cmd_out;
    end
  end

endmodule

// [verif/rpcl_listener_asserts.sv]
// checker: port properties of the command listener
`timescale 1ns/1ps
module rpcl_listener_asserts
  import rpcl_pkg::*;
(
  input wire logic               i_mclk,
  input wire logic               i_rst,
  input wire logic               i_rxd,
  input wire logic               i_jumper_enable,
  input wire logic               i_remote_power_enable_setting,
  input wire logic               i_system_powered,
  input wire rpcl_power_cmd_type o_power_cmd,
  input wire logic               o_sleeping,
  input wire logic               o_first_used
);
  // ------------------------------
  // properties
  // ------------------------------
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);
  logic cmd;
  logic allow;
  // any pulse, and the condition that lets a command through
  assign cmd = |o_power_cmd;
  assign allow = (i_remote_power_enable_setting & ~o_sleeping) |
                 (i_jumper_enable & ~i_system_powered & ~o_first_used);
  AST_ONE_CMD: assert property ($onehot0(o_power_cmd))
    else $error("two command pulses at once");
  AST_PULSE: assert property (cmd |=> !cmd)
    else $error("command pulse too long");
  AST_ALLOWED: assert property (cmd |-> $past(allow))
    else $error("command while not allowed");
  AST_SET_OFF: assert property (cmd && $past(i_system_powered) |->
    $past(i_remote_power_enable_setting))
    else $error("command with setting off");
  AST_ASLEEP: assert property (o_sleeping && $past(o_sleeping && i_system_powered)
    |-> !cmd)
    else $error("command while asleep");
  AST_WAKE: assert property ($rose(i_remote_power_enable_setting) |=> !o_sleeping)
    else $error("no wake on setting edge");
  AST_FIRST: assert property (o_power_cmd.power_on && !$past(i_remote_power_enable_setting)
    |-> ##[0:1] o_first_used)
    else $error("first power-on not marked");
  AST_STOP_BIT: assert property (cmd |-> $past(i_rxd) && $past(i_rxd, 2))
    else $error("command before stop bit");
  cover property (o_power_cmd.power_on);
  cover property (o_power_cmd.power_off_now);
  cover property ($rose(o_sleeping));
endmodule
bind rpcl_listener rpcl_listener_asserts i_rpcl_listener_asserts (.i_mclk, .i_rst, .i_rxd,
  .i_jumper_enable, .i_remote_power_enable_setting, .i_system_powered, .o_power_cmd,
  .o_sleeping, .o_first_used);

// [verif/rpcl_host_model.sv]
// partner model: serial terminal framing bytes on the receive line
`timescale 1ns/1ps
module rpcl_host_model
(
  input  wire logic i_mclk,
  output logic      o_rxd
);
  // line idles high between frames
  initial o_rxd = 1'b1;
  // start bit, eight data bits lsb first, stop bit, idle gap
  task automatic send_byte(input logic [7:0] b, input int bl);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge i_mclk);
      o_rxd <= frame[i];
      repeat (bl - 1) @(posedge i_mclk);
    end
    repeat (2 * bl) @(posedge i_mclk);
  endtask
endmodule

// [verif/test_remote_power_command_listener.sv]
// bench: command table, wake, bit-rate and overflow cases
`timescale 1ns/1ps
module test_remote_power_command_listener
  import rpcl_pkg::*;
;
  logic               i_mclk = 1'b0;
  logic               i_rst = 1'b1;
  logic               rxd;
  logic               jmp = 1'b0;
  logic               ena = 1'b0;
  logic               pwr = 1'b0;
  logic               slp;
  logic               used;
  rpcl_power_cmd_type cmd;
  rpcl_power_cmd_type seen = '0;
  logic               clr = 1'b0;
  int                 n_errors = 0;
  int                 n_checks = 0;
  int                 bl = 8;
  string              words [4] = '{"rsys^on", "rsys^off", "rsys^ton", "pic^sleep"};
  logic [8:0]         rows [8] = '{9'h018, 9'h010, 9'h0a0, 9'h0f4, 9'h172, 9'h078,
                                   9'h1f1, 9'h071};
  rpcl_host_model i_rpcl_host_model (.i_mclk(i_mclk), .o_rxd(rxd));
  rpcl_listener i_rpcl_listener (.i_mclk(i_mclk), .i_rst(i_rst), .i_rxd(rxd),
    .i_jumper_enable(jmp), .i_remote_power_enable_setting(ena), .i_system_powered(pwr),
    .o_power_cmd(cmd), .o_sleeping(slp), .o_first_used(used));
  // clock and pulse capture
  always #10 i_mclk = ~i_mclk;
  always @(posedge i_mclk)
    if (clr)
      seen <= '0;
    else if (|cmd)
      seen <= cmd;
  task automatic check(input string name, input logic [2:0] got, input logic [2:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // escape, word, enter
  task automatic send_cmd(input string w);
    clr <= 1'b1;
    @(posedge i_mclk);
    clr <= 1'b0;
    i_rpcl_host_model.send_byte(CHAR_ESC, bl);
    for (int k = 0; k < w.len(); k++)
      i_rpcl_host_model.send_byte(w[k], bl);
    i_rpcl_host_model.send_byte(CHAR_ENTER, bl);
    repeat (4) @(posedge i_mclk);
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ------------------------------
  // main sequence
  // ------------------------------
  initial
  begin
    repeat (2) @(posedge i_mclk);
    check("outputs in reset", {|cmd, slp, used}, 3'h0);
    i_rst <= 1'b0;
    foreach (rows[r])
    begin
      @(posedge i_mclk);
      {ena, pwr, jmp} <= rows[r][6:4];
      send_cmd(words[rows[r][8:7]]);
      check("command pulse", seen, rows[r][3:1]);
      check("sleep state", {2'h0, slp}, {2'h0, rows[r][0]});
    end
    check("first power-on used", {2'h0, used}, 3'h1);
    ena <= 1'b0; // firmware turns the setting off then on
    repeat (4) @(posedge i_mclk);
    ena <= 1'b1;
    repeat (2) @(posedge i_mclk);
    check("sleep after wake", {2'h0, slp}, 3'h0);
    for (int q = 0; q < 2; q++)
    begin
      bl = q ? 4 : 13;
      send_cmd(words[0]);
      check("on at new rate", seen, 3'h4);
    end
    bl = 8;
    send_cmd(words[3]);
    check("sleep entered", {2'h0, slp}, 3'h1);
    repeat (15) i_rpcl_host_model.send_byte(CHAR_ENTER, bl);
    check("sleep after overflow", {2'h0, slp}, 3'h0);
    send_cmd(words[1]);
    check("off after overflow", seen, 3'h2);
    test_done();
  end
  // watchdog
  initial
  begin
    repeat (60000) @(posedge i_mclk);
    n_errors++;
    test_done();
  end
endmodule
